// File: logic/csf_pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses for one card pin
module csf_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic clkEn,
  input  wire logic pinAsync,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic stage1_q, stage2_q, stage3_q;
  logic level_q, level_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  // ****************************************************************
  // Filter: a change counts only once stages two and three agree
  // ****************************************************************
  always_comb begin
    level_d = level_q;
    if (stage2_q == stage3_q) begin
      level_d = stage3_q;
    end
    rise_d = level_d & ~level_q;
    fall_d = ~level_d & level_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1_q <= IDLE_LEVEL;
      stage2_q <= IDLE_LEVEL;
      stage3_q <= IDLE_LEVEL;
      level_q  <= IDLE_LEVEL;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
    end else if (clkEn) begin
      stage1_q <= pinAsync;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= level_d;
      rise_q   <= rise_d;
      fall_q   <= fall_d;
    end
  end

  assign level = level_q;
  assign rise  = rise_q;
  assign fall  = fall_q;

endmodule : csf_pin_sync

// File: logic/csf_pkg.sv
// Constants shared by the socket status-change flag block
package csf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_WIDTH      = 8;
  localparam int          DATA_WIDTH      = 8;
  localparam int          FLAG_COUNT      = 4;
  localparam logic [7:0]  FLAGS_OFFSET    = 8'h04;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [3:0]  FLAG_RESET      = 4'h0;
  localparam logic [3:0]  UPPER_ZERO      = 4'h0;

  // ****************************************************************
  // Flag and enable bit positions
  // ****************************************************************
  localparam int          BIT_DETECT      = 3;
  localparam int          BIT_READY       = 2;
  localparam int          BIT_BATTERY_LOW = 1;
  localparam int          BIT_BATTERY_DEAD = 0;

  // ****************************************************************
  // Card pin indices; all card pins idle high
  // ****************************************************************
  localparam int          PIN_COUNT       = 5;
  localparam int          PIN_DETECT1     = 0;
  localparam int          PIN_DETECT2     = 1;
  localparam int          PIN_READY       = 2;
  localparam int          PIN_BATTERY_LOW = 3;
  localparam int          PIN_BATTERY_RING = 4;
  localparam logic        PIN_IDLE        = 1'b1;

  // ****************************************************************
  // Card kind and clear mode encodings
  // ****************************************************************
  typedef enum logic {
    CSF_MEMORY_CARD = 1'b0,
    CSF_IO_CARD     = 1'b1
  } csf_kind_type;

  typedef enum logic {
    CSF_CLEAR_ON_READ   = 1'b0,
    CSF_CLEAR_WRITE_ONE = 1'b1
  } csf_clear_type;

endpackage : csf_pkg

// File: logic/csf_status_flags.sv
// Socket status-change flag register with enable gating, clear modes and interrupt
//
// Function
// R1: Disabled source reads zero in its flag bit
// R2: Enabled source condition sets flag, raises interrupt
// R3: Global bit two picks read-clear or write-one-clear
// R4: Host reads flags, then clears those it handled
// R5: Bits seven to four always read zero
// R6: Bit three set on either card-detect change
// R7: Memory card: bit two set on READY rise
// R8: I/O card: READY flag held at zero
// R9: Memory card battery-low sets bit one; I/O zero
// R10: Memory card bit zero: battery dead asserted
// R11: Ring mode: bit zero reports ring input
// R12: Register resets to zero, read-only except clears
// R13: Per-source enables on bits three to zero
// R14: Ring enable selects ring function of input
// R15: Card kind bit selects memory or I/O meaning
// R16: Interrupt held while any enabled flag set
module csf_status_flags
  import csf_pkg::*;
#(
  parameter int PIN_NUM = csf_pkg::PIN_COUNT
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rstn,
  input  wire logic                           clkEn,
  input  wire logic [csf_pkg::ADDR_WIDTH-1:0] regAddr,
  input  wire logic                           regRead,
  input  wire logic                           regWrite,
  input  wire logic [csf_pkg::DATA_WIDTH-1:0] regWdata,
  output logic      [csf_pkg::DATA_WIDTH-1:0] regRdata,
  input  wire logic [csf_pkg::FLAG_COUNT-1:0] irqEnables,
  input  wire logic                           ring_function_enable,
  input  wire csf_pkg::csf_kind_type          card_kind_select,
  input  wire csf_pkg::csf_clear_type         clearMode,
  input  wire logic                           cardDetect1N,
  input  wire logic                           cardDetect2N,
  input  wire logic                           cardReady,
  input  wire logic                           batteryLowN,
  input  wire logic                           batteryDeadRingN,
  output logic                                statusIrq
);

  import csf_pkg::*;

  // ****************************************************************
  // Card pin synchronisers
  // ****************************************************************
  logic [PIN_NUM-1:0] pinRaw;
  logic [PIN_NUM-1:0] pinLevel;
  logic [PIN_NUM-1:0] pinRise;
  logic [PIN_NUM-1:0] pinFall;

  assign pinRaw[PIN_DETECT1]      = cardDetect1N;
  assign pinRaw[PIN_DETECT2]      = cardDetect2N;
  assign pinRaw[PIN_READY]        = cardReady;
  assign pinRaw[PIN_BATTERY_LOW]  = batteryLowN;
  assign pinRaw[PIN_BATTERY_RING] = batteryDeadRingN;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_NUM; gi++) begin : g_pin
      csf_pin_sync #(
        .IDLE_LEVEL (PIN_IDLE)
      ) u_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .clkEn    (clkEn),
        .pinAsync (pinRaw[gi]),
        .level    (pinLevel[gi]),
        .rise     (pinRise[gi]),
        .fall     (pinFall[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Event detection and set vector
  // ****************************************************************
  logic                  memoryCard;
  logic                  ringMode;
  logic [FLAG_COUNT-1:0] eventVec;
  logic [FLAG_COUNT-1:0] kindMask;
  logic [FLAG_COUNT-1:0] setVec;
  logic                  ringActive;

  always_comb begin
    memoryCard = (card_kind_select == CSF_MEMORY_CARD);                        // R15
    ringMode   = ring_function_enable;                                          // R14
    eventVec   = FLAG_RESET;
    kindMask   = {FLAG_COUNT{1'b1}};
    eventVec[BIT_DETECT] = pinRise[PIN_DETECT1] | pinFall[PIN_DETECT1]
                         | pinRise[PIN_DETECT2] | pinFall[PIN_DETECT2];       // R6
    eventVec[BIT_READY]        = pinRise[PIN_READY];                            // R7
    eventVec[BIT_BATTERY_LOW]  = pinFall[PIN_BATTERY_LOW];                      // R9
    // In ring mode bit zero is a live view, so it never latches
    eventVec[BIT_BATTERY_DEAD] = pinFall[PIN_BATTERY_RING] & ~ringMode;        // R10
    if (!memoryCard) begin
      kindMask[BIT_READY]       = 1'b0;                                         // R8
      kindMask[BIT_BATTERY_LOW] = 1'b0;                                         // R9
    end
    // A dead flag latched before ring mode would hold the interrupt
    // while hidden behind the live ring view, so it is dropped
    if (ringMode) begin
      kindMask[BIT_BATTERY_DEAD] = 1'b0;                                        // R11
    end
    setVec     = eventVec & irqEnables & kindMask;                              // R2 R13
    ringActive = ~pinLevel[PIN_BATTERY_RING];                                   // R11
  end

  // ****************************************************************
  // Flag register and read port
  // ****************************************************************
  logic [FLAG_COUNT-1:0] flags_q, flags_d;
  logic [DATA_WIDTH-1:0] rdata_q, rdata_d;
  logic                  irq_q, irq_d;
  logic                  rdHit;
  logic                  wrHit;
  logic [FLAG_COUNT-1:0] viewBits;
  logic [FLAG_COUNT-1:0] clearVec;

  always_comb begin
    rdHit    = regRead & (regAddr == FLAGS_OFFSET);
    wrHit    = regWrite & (regAddr == FLAGS_OFFSET);
    viewBits = flags_q & irqEnables & kindMask;                                 // R1
    if (ringMode) begin
      viewBits[BIT_BATTERY_DEAD] = ringActive & irqEnables[BIT_BATTERY_DEAD];  // R11
    end
    clearVec = FLAG_RESET;
    if (clearMode == CSF_CLEAR_ON_READ) begin
      // Only bits the host actually saw are cleared, so nothing is lost
      if (rdHit) begin
        clearVec = viewBits;                                                    // R3
      end
    end else if (wrHit) begin
      clearVec = regWdata[FLAG_COUNT-1:0];                                      // R3
    end
    // Set beats clear; disabled or masked sources cannot hold a flag
    flags_d = ((flags_q & ~clearVec) | setVec) & irqEnables & kindMask;        // R1 R2
    rdata_d = rdata_q;
    if (rdHit) begin
      rdata_d = {UPPER_ZERO, viewBits};                                         // R5
    end
    irq_d = |flags_d;                                                           // R16
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_q <= FLAG_RESET;                                                    // R12
      rdata_q <= FLAGS_RESET;
      irq_q   <= 1'b0;
    end else if (clkEn) begin
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  assign regRdata  = rdata_q;
  assign statusIrq = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  upper_zero_a: assert property ( // R5
    regRdata[DATA_WIDTH-1:FLAG_COUNT] == UPPER_ZERO)
    else $error("upper status bits not zero");

  disabled_reads_a: assert property ( // R1
    clkEn && rdHit && !irqEnables[BIT_DETECT]
      |=> !regRdata[BIT_DETECT])
    else $error("disabled source read as set");

  disabled_flag_a: assert property ( // R1
    clkEn
      |=> (flags_q & ~$past(irqEnables)) == FLAG_RESET)
    else $error("flag held by a disabled source");

  io_ready_a: assert property ( // R8
    clkEn && card_kind_select == CSF_IO_CARD
      |=> !flags_q[BIT_READY])
    else $error("ready flag set with io card");

  io_battery_a: assert property ( // R9
    clkEn && card_kind_select == CSF_IO_CARD
      |=> !flags_q[BIT_BATTERY_LOW])
    else $error("battery low flag set with io card");

  // ****************************************************************
  // Checks: events set flags and raise the interrupt, flags three to one stay clear without an event, and bit zero stays clear in ring mode
  // ****************************************************************

  detect_set_a: assert property ( // R6
    clkEn && setVec[BIT_DETECT]
      |=> flags_q[BIT_DETECT] && statusIrq)
    else $error("detect event did not set flag and interrupt");

  ready_set_a: assert property ( // R7
    clkEn && setVec[BIT_READY]
      |=> flags_q[BIT_READY] && statusIrq)
    else $error("ready rise did not set flag and interrupt");

  battery_low_set_a: assert property ( // R9
    clkEn && setVec[BIT_BATTERY_LOW]
      |=> flags_q[BIT_BATTERY_LOW] && statusIrq)
    else $error("battery low did not set flag and interrupt");

  battery_dead_set_a: assert property ( // R10
    clkEn && setVec[BIT_BATTERY_DEAD]
      |=> flags_q[BIT_BATTERY_DEAD] && statusIrq)
    else $error("battery dead did not set flag and interrupt");

  irq_set_a: assert property ( // R2
    clkEn && (|setVec)
      |=> statusIrq)
    else $error("event did not raise interrupt");

  detect_quiet_a: assert property ( // R6
    clkEn && !setVec[BIT_DETECT] && !flags_q[BIT_DETECT]
      |=> !flags_q[BIT_DETECT])
    else $error("detect flag set without a change");

  ready_quiet_a: assert property ( // R7
    clkEn && !setVec[BIT_READY] && !flags_q[BIT_READY]
      |=> !flags_q[BIT_READY])
    else $error("ready flag set without a rise");

  battery_quiet_a: assert property ( // R9
    clkEn && !setVec[BIT_BATTERY_LOW] && !flags_q[BIT_BATTERY_LOW]
      |=> !flags_q[BIT_BATTERY_LOW])
    else $error("battery low flag set without a warning");

  ring_no_latch_a: assert property ( // R11
    clkEn && ringMode
      |=> !flags_q[BIT_BATTERY_DEAD])
    else $error("bit zero latched in ring mode");

  // ****************************************************************
  // Checks: clearing, read port and freeze
  // ****************************************************************

  irq_track_a: assert property ( // R16
    clkEn
      |=> statusIrq == (|flags_q))
    else $error("interrupt disagrees with flags");

  irq_clear_a: assert property ( // R16
    clkEn && setVec == FLAG_RESET && (flags_q & ~clearVec) == FLAG_RESET
      |=> !statusIrq)
    else $error("interrupt kept after all flags cleared");

  read_clear_a: assert property ( // R3
    clkEn && rdHit && clearMode == CSF_CLEAR_ON_READ && viewBits[BIT_READY]
      && !setVec[BIT_READY] |=> !flags_q[BIT_READY])
    else $error("read did not clear ready flag");

  write_clear_a: assert property ( // R3
    clkEn && wrHit && clearMode == CSF_CLEAR_WRITE_ONE && regWdata[BIT_BATTERY_LOW]
      && !setVec[BIT_BATTERY_LOW] |=> !flags_q[BIT_BATTERY_LOW])
    else $error("write of one did not clear battery flag");

  set_wins_a: assert property ( // R2
    clkEn && wrHit && clearMode == CSF_CLEAR_WRITE_ONE && regWdata[BIT_BATTERY_DEAD]
      && setVec[BIT_BATTERY_DEAD] |=> flags_q[BIT_BATTERY_DEAD])
    else $error("set lost against clear");

  write_refused_a: assert property ( // R3
    clkEn && wrHit && clearMode == CSF_CLEAR_ON_READ && !rdHit
      |=> ($past(flags_q) & $past(irqEnables) & $past(kindMask) & ~flags_q) == FLAG_RESET)
    else $error("write cleared flags in clear-on-read mode");

  read_keep_a: assert property ( // R12
    clkEn && rdHit && clearMode == CSF_CLEAR_WRITE_ONE && !wrHit
      |=> ($past(flags_q) & $past(irqEnables) & $past(kindMask) & ~flags_q) == FLAG_RESET)
    else $error("read changed flags in write-one mode");

  unmapped_write_a: assert property ( // R12
    clkEn && regWrite && regAddr != FLAGS_OFFSET && !rdHit
      |=> ($past(flags_q) & $past(irqEnables) & $past(kindMask) & ~flags_q) == FLAG_RESET)
    else $error("write to another address cleared flags");

  read_data_a: assert property ( // R11
    clkEn && rdHit
      |=> regRdata[FLAG_COUNT-1:0] == $past(viewBits))
    else $error("read data not the flag view");

  ring_live_a: assert property ( // R11
    clkEn && rdHit && ringMode
      |=> regRdata[BIT_BATTERY_DEAD] == ($past(ringActive) & $past(irqEnables[BIT_BATTERY_DEAD])))
    else $error("ring view not the ring input");

  rdata_hold_a: assert property ( // R12
    clkEn && !rdHit
      |=> $stable(regRdata))
    else $error("read data changed without a read");

  freeze_a: assert property (
    !clkEn
      |=> $stable(flags_q) && $stable(regRdata) && $stable(statusIrq))
    else $error("state moved with clock enable low");

endmodule : csf_status_flags

// File: sim/card_status_change_flags_tb.sv
// Self-checking bench for the socket status-change flag block
module card_status_change_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import csf_pkg::*;
  typedef struct {
    logic [3:0] en;
    logic       kind;
    logic       ring;
    logic [4:0] pins;
    logic [7:0] exp1;
    logic [7:0] exp2;
    logic       irq;
  } csf_row_type;
  // ****************************************************************
  // Signals
  // ****************************************************************
  // Ready idles low so that driving it high is a rise
  localparam logic [4:0] BASE = 5'b11011;
  logic          clk_sys   = 1'b0;
  logic          rstn      = 1'b0;
  logic          regRead   = 1'b0;
  logic          regWrite  = 1'b0;
  logic          ringOn    = 1'b0;
  logic          clkEn     = 1'b1;
  logic [7:0]    regAddr   = 8'h04;
  logic [7:0]    regWdata  = 8'h00;
  logic [7:0]    regRdata;
  logic [7:0]    rdData;
  logic [3:0]    irqEn     = 4'hF;
  logic [4:0]    pins      = BASE;
  logic          statusIrq;
  logic          det1N, det2N, rdy, batLowN, batDeadN;
  csf_kind_type  kind      = CSF_MEMORY_CARD;
  csf_clear_type clrMode   = CSF_CLEAR_ON_READ;
  int            fails      = 0;
  int            n_compared = 0;
  int            cycles     = 0;
  csf_row_type   rows [10] = '{
    '{4'hF, 1'b0, 1'b0, 5'b11010, 8'h08, 8'h00, 1'b1},
    '{4'h0, 1'b0, 1'b0, 5'b11010, 8'h00, 8'h00, 1'b0},
    '{4'h7, 1'b0, 1'b0, 5'b11001, 8'h00, 8'h00, 1'b0},
    '{4'hF, 1'b0, 1'b0, 5'b11111, 8'h04, 8'h00, 1'b1},
    '{4'hF, 1'b1, 1'b0, 5'b11111, 8'h00, 8'h00, 1'b0},
    '{4'hF, 1'b0, 1'b0, 5'b10011, 8'h02, 8'h00, 1'b1},
    '{4'hF, 1'b1, 1'b0, 5'b10011, 8'h00, 8'h00, 1'b0},
    '{4'hF, 1'b0, 1'b0, 5'b01011, 8'h01, 8'h00, 1'b1},
    '{4'hF, 1'b0, 1'b1, 5'b01011, 8'h01, 8'h01, 1'b0},
    '{4'hE, 1'b0, 1'b1, 5'b01011, 8'h00, 8'h00, 1'b0}
  };
  always #2.5 clk_sys = ~clk_sys;
  csf_status_flags u_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .irqEnables(irqEn), .ring_function_enable(ringOn), .card_kind_select(kind),
    .clearMode(clrMode), .cardDetect1N(det1N), .cardDetect2N(det2N), .cardReady(rdy),
    .batteryLowN(batLowN), .batteryDeadRingN(batDeadN), .statusIrq(statusIrq));
  csf_card_model u_card (.pinLevels(pins), .cardDetect1N(det1N), .cardDetect2N(det2N),
    .cardReady(rdy), .batteryLowN(batLowN), .batteryDeadRingN(batDeadN));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_n(input int n);
    repeat (n) tick();
  endtask : wait_n
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRead = 1'b1;
    tick();
    regRead = 1'b0;
    d = regRdata;
    tick();
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    tick();
    regWrite = 1'b0;
    tick();
  endtask : wr
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rstn = 1'b1;
    chk("reset regRdata", 8'h00, regRdata);
    chk("reset statusIrq", 8'h00, {7'h00, statusIrq});
    wait_n(8);
    rd(8'h04, rdData);
    chk("reset flags", 8'h00, rdData);
    $display("reset test done");
    foreach (rows[i]) begin
      irqEn  = rows[i].en;
      kind   = csf_kind_type'(rows[i].kind);
      ringOn = rows[i].ring;
      pins   = rows[i].pins;
      wait_n(8);
      chk("statusIrq", {7'h00, rows[i].irq}, {7'h00, statusIrq});
      rd(8'h04, rdData);
      chk("flags", rows[i].exp1, rdData);
      rd(8'h04, rdData);
      chk("flags after read", rows[i].exp2, rdData);
      pins   = BASE;
      ringOn = 1'b0;
      wait_n(8);
      rd(8'h04, rdData);
      $display("row %0d done", i);
    end
    irqEn = 4'hF;
    kind  = CSF_MEMORY_CARD;
    pins  = 5'b10010;
    wait_n(8);
    wr(8'h04, 8'h0A);
    chk("irq after refused write", 8'h01, {7'h00, statusIrq});
    clrMode = CSF_CLEAR_WRITE_ONE;
    rd(8'h04, rdData);
    chk("write-one flags", 8'h0A, rdData);
    rd(8'h05, rdData);
    chk("unmapped read", 8'h0A, rdData);
    wr(8'h05, 8'h0F);
    rd(8'h04, rdData);
    chk("flags kept", 8'h0A, rdData);
    wr(8'h04, 8'hF2);
    rd(8'h04, rdData);
    chk("partial clear", 8'h08, rdData);
    chk("irq still held", 8'h01, {7'h00, statusIrq});
    wr(8'h04, 8'h08);
    chk("irq dropped", 8'h00, {7'h00, statusIrq});
    rd(8'h04, rdData);
    chk("all cleared", 8'h00, rdData);
    $display("write-one test done");
    pins = BASE;
    wait_n(8);
    clkEn = 1'b0;
    rd(8'h04, rdData);
    chk("frozen read", 8'h00, rdData);
    wr(8'h04, 8'h08);
    chk("frozen irq", 8'h01, {7'h00, statusIrq});
    clkEn = 1'b1;
    rd(8'h04, rdData);
    chk("flag after thaw", 8'h08, rdData);
    $display("freeze test done");
    // Write lands on the very edge at which the dead event sets bit zero
    pins = 5'b01011;
    wait_n(4);
    wr(8'h04, 8'h01);
    rd(8'h04, rdData);
    chk("set beats clear", 8'h09, rdData);
    $display("set-wins test done");
    pins = BASE;
    wait_n(8);
    rstn = 1'b0;
    tick();
    chk("mid reset irq", 8'h00, {7'h00, statusIrq});
    chk("mid reset regRdata", 8'h00, regRdata);
    rstn = 1'b1;
    wait_n(8);
    rd(8'h04, rdData);
    chk("flags after reset", 8'h00, rdData);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : card_status_change_flags_tb

// File: sim/csf_card_model.sv
// Behavioural card in the socket that drives its status pins
module csf_card_model
  import csf_pkg::*;
(
  input  wire logic [csf_pkg::PIN_COUNT-1:0] pinLevels,
  output logic                               cardDetect1N,
  output logic                               cardDetect2N,
  output logic                               cardReady,
  output logic                               batteryLowN,
  output logic                               batteryDeadRingN
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Pins
  // ****************************************************************
  // A seated card always drives its pins, so they are never left floating
  assign cardDetect1N     = pinLevels[PIN_DETECT1];
  assign cardDetect2N     = pinLevels[PIN_DETECT2];
  assign cardReady        = pinLevels[PIN_READY];
  assign batteryLowN      = pinLevels[PIN_BATTERY_LOW];
  assign batteryDeadRingN = pinLevels[PIN_BATTERY_RING];
endmodule : csf_card_model
